/* File: design/cht_pkg.sv */
package cht_pkg;

    // ******************************************************
    // sample format and rates
    // ******************************************************
    localparam int unsigned FS_HZ = 48_000;         // audio frame rate, sets delay depth in frames
    localparam logic [23:0] FULL_SCALE = 24'h7fffff; // largest positive dac code
    localparam logic [23:0] HALF_SCALE = 24'h400000; // mode 1 doubling saturates from here

    // ******************************************************
    // register map, byte addresses
    // ******************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;    // tracking controls
    localparam logic [7:0] REG_VOL = 8'h04;     // tracking gain level
    localparam logic [7:0] REG_SLOT_EN = 8'h08; // one enable bit per input slot
    localparam logic [7:0] REG_ENV = 8'h0c;     // envelope, read only
    localparam logic [7:0] REG_PEAK = 8'h10;    // last frame peak, read only

    // ******************************************************
    // reset values and field positions
    // ******************************************************
    localparam logic [11:0] CTRL_RST = 12'h040;    // tracking filter, mode 0, least headroom
    localparam logic [7:0] VOL_RST = 8'h10;        // 0 dB
    localparam logic [31:0] SLOT_EN_RST = 32'hffffffff;
    localparam int CTRL_HEAD_LSB = 0;  // headroom_offset_sel [2:0]
    localparam int CTRL_MODE_BIT = 3;  // supply_polarity_mode
    localparam int CTRL_GSEL_BIT = 4;  // mode1_gain_sel
    localparam int CTRL_FLT_LSB = 5;   // fifth_path_filter_sel [1:0]
    localparam int CTRL_INV_BIT = 7;   // fifth_path_invert
    localparam int CTRL_GD_LSB = 8;    // group delay select [3:0]
    localparam logic [1:0] FLT_TRACK = 2'b10;
    localparam logic [7:0] VOL_MUTE_MIN = 8'hed; // codes from here mute the path
    localparam int DECAY_SHIFT = 6;              // envelope release per frame

    // ******************************************************
    // lead time
    // ******************************************************
    localparam int unsigned GD_MIN_US = 100;
    localparam int unsigned GD_MAX_US = 500;
    localparam int unsigned GD_STEPS = 15;
    localparam int DLY_AW = 6;
    localparam int DLY_DEPTH = 64;

    // delay select to frames, rounded down
    function automatic logic [5:0] cht_gd_frames(input logic [3:0] sel);
        int unsigned us;
        us = GD_MIN_US + (32'(sel) * (GD_MAX_US - GD_MIN_US)) / GD_STEPS;
        return 6'((us * FS_HZ) / 1_000_000);
    endfunction

    // headroom select to offset, percent of full scale
    function automatic logic [23:0] cht_offset(input logic [2:0] sel);
        int unsigned pct;
        case (sel)
            3'h0: pct = 0;
            3'h1: pct = 1;
            3'h2: pct = 2;
            3'h3: pct = 3;
            3'h4: pct = 5;
            3'h5: pct = 7;
            3'h6: pct = 10;
            default: pct = 15;
        endcase
        return 24'((32'(FULL_SCALE) * pct) / 100);
    endfunction

    // 2^(-k/16) in q1.15, one sixteenth of 6.02 dB per step
    function automatic logic [15:0] cht_mant(input logic [3:0] k);
        case (k)
            4'h0: return 16'h8000;
            4'h1: return 16'h7a93;
            4'h2: return 16'h7560;
            4'h3: return 16'h7066;
            4'h4: return 16'h6ba2;
            4'h5: return 16'h6712;
            4'h6: return 16'h62b4;
            4'h7: return 16'h5e84;
            4'h8: return 16'h5a82;
            4'h9: return 16'h56ac;
            4'ha: return 16'h52ff;
            4'hb: return 16'h4f7b;
            4'hc: return 16'h4c1c;
            4'hd: return 16'h48e2;
            4'he: return 16'h45cb;
            default: return 16'h42d6;
        endcase
    endfunction

    // tracking sequence, gray along the path
    typedef enum logic [1:0] {
        CHT_IDLE = 2'b00,
        CHT_ENV = 2'b01,
        CHT_SUM = 2'b11,
        CHT_OUT = 2'b10
    } cht_state_t;

endpackage

/* File: design/cht_track_gain.sv */
module cht_track_gain import cht_pkg::*; (
    input wire logic [23:0] mag_in,
    input wire logic [7:0] level,
    output logic [23:0] gain_out
);

    // ******************************************************
    // gain stage, +6.02 dB at level 0, 0.376 dB per step
    // ******************************************************
    logic [39:0] prod; // magnitude times mantissa
    logic [39:0] shifted; // after octave shift, q1.15 times two

    // mute codes force zero; product saturates at full scale
    always_comb begin
        prod = 40'(mag_in) * 40'(cht_mant(level[3:0]));
        shifted = (prod >> 14) >> level[7:4];
        if (level >= VOL_MUTE_MIN) begin
            gain_out = 24'h000000;
        end else if (shifted > 40'(FULL_SCALE)) begin
            gain_out = FULL_SCALE;
        end else begin
            gain_out = shifted[23:0];
        end
    end

endmodule

/* File: design/cht_group_delay.sv */
module cht_group_delay import cht_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [23:0] in_data,
    input wire logic [5:0] frames,
    output logic out_valid,
    output logic [23:0] out_data
);

    // ******************************************************
    // state
    // ******************************************************
    typedef struct packed {
        logic [DLY_AW-1:0] wr_ptr; // next slot to write
        logic [DLY_AW:0] fill; // words written since reset, saturating
        logic out_valid;
        logic [23:0] out_data;
    } cht_dly_st_t;

    cht_dly_st_t st;
    cht_dly_st_t next_st;
    logic [23:0] mem [DLY_DEPTH]; // sample history, no reset needed
    logic [23:0] rd_word; // sample written frames ago

    // ******************************************************
    // delay line
    // ******************************************************
    // read before write, so zero frames must bypass the memory
    always_comb begin
        rd_word = mem[st.wr_ptr - frames];
        next_st = st;
        next_st.out_valid = in_valid;
        if (in_valid) begin
            next_st.wr_ptr = st.wr_ptr + 6'h01;
            if (st.fill != 7'(DLY_DEPTH)) begin
                next_st.fill = st.fill + 7'h01;
            end
            next_st.out_data = (frames == 6'h00) ? in_data : rd_word;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // history write, one word per frame
    always_ff @(posedge clk) begin
        if (in_valid) begin
            mem[st.wr_ptr] <= in_data;
        end
    end

    assign out_valid = st.out_valid;
    assign out_data = st.out_data;

    // taps not yet written hold no defined word, so they are left out
    a_delay_tap: assert property (@(posedge clk) disable iff (!rst_n)
        in_valid && frames != 6'h00 && {1'b0, frames} <= st.fill |=> out_valid && out_data == $past(rd_word))
        else $error("delayed sample not taken from the selected tap");

endmodule

/* File: design/cht_tracker.sv */
// How it works
// - tracking follows envelope of largest channel, 32 slots
// - processed tracking signal drives fifth dac output
// - headroom select adds dc offset of full scale
// - audio path delayed 100 to 500 us
// - gain level spans +6 to -83 dB
// - filter select 10 enables tracking operation
// - invert control ignored while tracking
// - mode 0 references zero, mode 1 full scale
// - mode 1 applies gain one or two
module cht_tracker import cht_pkg::*; (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic slot_valid,
    input wire logic [4:0] slot_index,
    input wire logic [23:0] slot_data,
    input wire logic frame_end,
    input wire logic aud_valid,
    input wire logic [23:0] aud_data,
    input wire logic aud5_valid,
    input wire logic [23:0] aud5_data,
    output logic dly_valid,
    output logic [23:0] dly_data,
    output logic dac5_valid,
    output logic [23:0] dac5_data
);

    // ******************************************************
    // state
    // ******************************************************
    typedef struct packed {
        logic wreq; // avalon waitrequest
        logic [31:0] rdata; // read data, stands at the accepting edge
        logic [11:0] ctrl; // tracking controls
        logic [7:0] vol; // track_gain_level
        logic [31:0] slot_en; // input slot enables
        logic [23:0] peak; // running peak of this frame
        logic [23:0] peak_hold; // peak of the last frame
        logic [23:0] env; // envelope
        logic [23:0] trk; // envelope plus headroom
        cht_state_t fsm;
        logic dac5_valid;
        logic [23:0] dac5_data;
    } cht_st_t;

    cht_st_t st;
    cht_st_t next_st;
    logic [1:0] rst_q; // reset release synchroniser
    logic rst_n; // released reset for the design

    // field views of the control register
    logic [2:0] headroom_offset_sel;
    logic supply_polarity_mode;
    logic mode1_gain_sel;
    logic [1:0] fifth_path_filter_sel;
    logic fifth_path_invert;
    logic [3:0] gd_sel;
    logic tracking; // fifth path in tracking operation

    logic [23:0] slot_mag; // magnitude of the arriving slot
    logic [23:0] frame_peak; // peak including a slot on the frame edge
    logic [23:0] decay; // envelope release step
    logic [24:0] sum; // envelope plus offset, one bit of carry
    logic [23:0] gained; // gain stage output
    logic [23:0] doubled; // after mode 1 gain
    logic [31:0] wmask; // byte lanes of a write

    // ******************************************************
    // reset release
    // ******************************************************
    // assert at once, release after two edges
    // the async clear keeps a glitch-free release inside the clock domain
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    assign headroom_offset_sel = st.ctrl[CTRL_HEAD_LSB +: 3];
    assign supply_polarity_mode = st.ctrl[CTRL_MODE_BIT];
    assign mode1_gain_sel = st.ctrl[CTRL_GSEL_BIT];
    assign fifth_path_filter_sel = st.ctrl[CTRL_FLT_LSB +: 2];
    assign fifth_path_invert = st.ctrl[CTRL_INV_BIT];
    assign gd_sel = st.ctrl[CTRL_GD_LSB +: 4];
    assign tracking = (fifth_path_filter_sel == FLT_TRACK);

    // ******************************************************
    // gain matching and lead time
    // ******************************************************
    // gain follows headroom, so the offset scales with the level as well
    // level codes from the mute threshold up force the stage to zero
    cht_track_gain u_gain (
        .mag_in(st.trk),
        .level(st.vol),
        .gain_out(gained)
    );

    // only the audio path waits; the tracking path leaves at once, so the
    // supply rails move ahead of the audio
    cht_group_delay u_delay (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(aud_valid),
        .in_data(aud_data),
        .frames(cht_gd_frames(gd_sel)),
        .out_valid(dly_valid),
        .out_data(dly_data)
    );

    // ******************************************************
    // next state
    // ******************************************************
    always_comb begin
        next_st = st;
        wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        // magnitude, most negative code clamps to full scale
        slot_mag = slot_data[23] ? 24'(-slot_data) : slot_data;
        if (slot_mag > FULL_SCALE) begin
            slot_mag = FULL_SCALE;
        end
        frame_peak = st.peak;
        if (slot_valid && st.slot_en[slot_index] && slot_mag > st.peak) begin
            frame_peak = slot_mag;
        end
        // release step never below one code, so the envelope reaches zero
        decay = (st.env >> DECAY_SHIFT) | 24'(st.env != 24'h000000);
        sum = {1'b0, st.env} + {1'b0, cht_offset(headroom_offset_sel)};
        doubled = gained;
        if (supply_polarity_mode && mode1_gain_sel) begin
            doubled = (gained >= HALF_SCALE) ? FULL_SCALE : {gained[22:0], 1'b0};
        end

        // bus slave: one wait cycle, then the access completes
        // every access costs two cycles, the price of a registered waitrequest
        next_st.wreq = 1'b1;
        if (st.wreq && (avs_read || avs_write)) begin
            next_st.wreq = 1'b0;
            next_st.rdata = 32'h00000000;
            if (avs_read) begin
                unique case (avs_address)
                    REG_CTRL: next_st.rdata = 32'(st.ctrl);
                    REG_VOL: next_st.rdata = 32'(st.vol);
                    REG_SLOT_EN: next_st.rdata = st.slot_en;
                    REG_ENV: next_st.rdata = 32'(st.env);
                    REG_PEAK: next_st.rdata = 32'(st.peak_hold);
                    default: next_st.rdata = 32'h00000000; // unmapped reads zero
                endcase
            end
        end
        // write lands at the edge that sees waitrequest low
        if (!st.wreq && avs_write) begin
            unique case (avs_address)
                REG_CTRL: next_st.ctrl = (st.ctrl & ~wmask[11:0]) | (avs_writedata[11:0] & wmask[11:0]);
                REG_VOL: next_st.vol = (st.vol & ~wmask[7:0]) | (avs_writedata[7:0] & wmask[7:0]);
                REG_SLOT_EN: next_st.slot_en = (st.slot_en & ~wmask) | (avs_writedata & wmask);
                default: next_st.ctrl = st.ctrl; // read only or unmapped, dropped
            endcase
        end

        // per frame peak, restarted at each frame edge taken in CHT_IDLE
        next_st.peak = frame_peak;
        next_st.dac5_valid = 1'b0;

        // tracking sequence; frame edges while busy are dropped
        // limitation: frames must close at least four cycles apart
        unique case (st.fsm)
            CHT_IDLE: begin
                if (frame_end) begin
                    next_st.peak_hold = frame_peak;
                    next_st.peak = 24'h000000;
                    next_st.fsm = CHT_ENV;
                end
            end
            CHT_ENV: begin
                // instant attack, slow release
                if (st.peak_hold >= st.env - decay) begin
                    next_st.env = st.peak_hold;
                end else begin
                    next_st.env = st.env - decay;
                end
                next_st.fsm = CHT_SUM;
            end
            CHT_SUM: begin
                // headroom before gain, saturating
                next_st.trk = sum[24] || sum[23:0] > FULL_SCALE ? FULL_SCALE : sum[23:0];
                next_st.fsm = CHT_OUT;
            end
            CHT_OUT: begin
                if (tracking) begin
                    // invert is not looked at here
                    next_st.dac5_valid = 1'b1;
                    next_st.dac5_data = supply_polarity_mode ? FULL_SCALE - doubled : doubled;
                end
                next_st.fsm = CHT_IDLE;
            end
        endcase

        // plain audio on the fifth path when not tracking
        // invert acts only here, never on the tracking value
        if (!tracking && aud5_valid) begin
            next_st.dac5_valid = 1'b1;
            next_st.dac5_data = fifth_path_invert ? 24'(-aud5_data) : aud5_data;
        end
    end

    // ******************************************************
    // state register
    // ******************************************************
    // tracker state in one register; bus and fifth dac outputs come straight from it, dly_valid and dly_data from u_delay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{wreq: 1'b1, rdata: 32'h00000000, ctrl: CTRL_RST, vol: VOL_RST,
                   slot_en: SLOT_EN_RST, peak: 24'h000000, peak_hold: 24'h000000,
                   env: 24'h000000, trk: 24'h000000, fsm: CHT_IDLE,
                   dac5_valid: 1'b0, dac5_data: 24'h000000};
        end else begin
            st <= next_st;
        end
    end

    assign avs_waitrequest = st.wreq;
    assign avs_readdata = st.rdata;
    assign dac5_valid = st.dac5_valid;
    assign dac5_data = st.dac5_data;

    // ******************************************************
    // checks
    // ******************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // checks sleep until the released reset rises

    a_peak_enabled: assert property (
        slot_valid && st.slot_en[slot_index] && !frame_end |=> st.peak >= $past(slot_mag))
        else $error("enabled slot magnitude missed by frame peak");
    a_peak_masked: assert property (
        slot_valid && !st.slot_en[slot_index] && !frame_end && st.fsm == CHT_IDLE |=> $stable(st.peak))
        else $error("disabled slot changed frame peak");
    a_env_attack: assert property (
        st.fsm == CHT_IDLE && frame_end |=> ##1 st.env >= $past(st.peak_hold))
        else $error("envelope below frame peak");
    a_headroom_floor: assert property (
        st.fsm == CHT_SUM && $stable(st.ctrl) |=> st.trk >= cht_offset(headroom_offset_sel))
        else $error("tracking value below headroom offset");
    a_track_route: assert property (
        st.fsm == CHT_OUT && tracking |=> dac5_valid)
        else $error("tracking sample not sent to fifth dac");
    a_mute_zero: assert property (
        st.fsm == CHT_OUT && tracking && !supply_polarity_mode && st.vol >= VOL_MUTE_MIN
        |=> dac5_data == 24'h000000)
        else $error("muted mode 0 tracking not at zero");
    a_mode1_ref: assert property (
        st.fsm == CHT_OUT && tracking && supply_polarity_mode && st.vol >= VOL_MUTE_MIN
        |=> dac5_data == FULL_SCALE)
        else $error("muted mode 1 tracking not at full scale");
    a_mode1_double: assert property (
        st.fsm == CHT_OUT && tracking && supply_polarity_mode && mode1_gain_sel && gained >= HALF_SCALE
        |=> dac5_data == 24'h000000)
        else $error("mode 1 doubling did not saturate");
    a_no_invert: assert property (
        dac5_valid && $past(tracking) && $past(st.fsm) == CHT_OUT |-> !dac5_data[23] || supply_polarity_mode)
        else $error("tracking output went negative");
    a_pass_audio: assert property (
        !tracking && aud5_valid && !fifth_path_invert |=> dac5_valid && dac5_data == $past(aud5_data))
        else $error("plain audio not passed on fifth path");

    // ******************************************************
    // output stage, peak restart and envelope release checks
    // ******************************************************
    a_aud5_ignored: assert property (
        tracking && st.fsm != CHT_OUT |=> !dac5_valid)
        else $error("plain audio reached fifth dac while tracking");
    a_gain_mute: assert property (
        st.vol >= VOL_MUTE_MIN |-> gained == 24'h000000)
        else $error("mute level left gain stage open");
    a_mode0_ref: assert property (
        st.fsm == CHT_OUT && tracking && !supply_polarity_mode |=> dac5_data == $past(gained))
        else $error("mode 0 tracking not referenced to zero");
    a_mode1_unity: assert property (
        st.fsm == CHT_OUT && tracking && supply_polarity_mode && !mode1_gain_sel
        |=> dac5_data == FULL_SCALE - $past(gained))
        else $error("mode 1 unity gain not applied");
    a_plain_invert: assert property (
        !tracking && aud5_valid && fifth_path_invert |=> dac5_valid && dac5_data == 24'(-$past(aud5_data)))
        else $error("plain audio not inverted on fifth path");
    a_peak_restart: assert property (
        st.fsm == CHT_IDLE && frame_end |=> st.peak == 24'h000000)
        else $error("frame peak not restarted at frame edge");
    a_env_release: assert property (
        st.fsm == CHT_ENV && st.peak_hold < st.env - decay |=> st.env < $past(st.env))
        else $error("envelope did not release");

endmodule

/* File: dv/cht_supply_model.sv */
// ****
// far side: tracking supply modulator
// ****
module cht_supply_model (
    input wire logic clk,
    input wire logic dac5_valid,
    input wire logic [23:0] dac5_data,
    output logic [23:0] rail_code
);
    timeunit 1ns;
    timeprecision 1ns;
    // latch each control code and hold it between updates, like a modulator input
    always_ff @(posedge clk) begin
        if (dac5_valid === 1'b1) begin
            rail_code <= dac5_data;
        end
    end
endmodule

/* File: dv/cht_tracker_tb.sv */
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module cht_tracker_tb import cht_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // signals
    // ****
    logic clk, resetn, avs_read, avs_write, avs_waitrequest;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic slot_valid, frame_end, aud_valid, aud5_valid, dly_valid, dac5_valid, vld;
    logic [4:0] slot_index;
    logic [23:0] slot_data, aud_data, aud5_data, dly_data, dac5_data, rail_code, got, dat;
    int fails, n_checks, cyc, nd;
    int pct[8] = '{0, 1, 2, 3, 5, 7, 10, 15}; // headroom percent per select
    // gain and mode table: ctrl, level, expected code with envelope 0x100000
    logic [11:0] tc[10] = '{12'h040, 12'h040, 12'h040, 12'h048, 12'h058, 12'h058, 12'h0c0, 12'h050,
                            12'h05f, 12'h048};
    logic [7:0] tv[10] = '{8'h00, 8'h20, 8'hed, 8'h10, 8'h10, 8'h00, 8'h10, 8'h10, 8'h00, 8'hed};
    logic [23:0] te[10] = '{24'h200000, 24'h080000, 24'h000000, 24'h6fffff, 24'h5fffff, 24'h3fffff,
                            24'h100000, 24'h100000, 24'h000000, 24'h7fffff};
    cht_tracker dut (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .slot_valid(slot_valid),
        .slot_index(slot_index), .slot_data(slot_data), .frame_end(frame_end), .aud_valid(aud_valid),
        .aud_data(aud_data), .aud5_valid(aud5_valid), .aud5_data(aud5_data), .dly_valid(dly_valid),
        .dly_data(dly_data), .dac5_valid(dac5_valid), .dac5_data(dac5_data));
    cht_supply_model smps (.clk(clk), .dac5_valid(dac5_valid), .dac5_data(dac5_data), .rail_code(rail_code));
    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // hang guard, far above the several hundred cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_of_test();
        end
    end
    // ****
    // tasks
    // ****
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic do_reset;
        resetn <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk); // two-stage release plus margin
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        av(1'b1, a, d, 4'hf);
    endtask
    task automatic chkrd(input string nm, input logic [7:0] a, input logic [31:0] e);
        av(1'b0, a, 32'h0, 4'h0);
        `CHK(nm, e, rd)
    endtask
    // slot 0 and slot 31 then close the frame; result taken from the supply side
    task automatic frame(input logic [23:0] d0, input logic [23:0] d31);
        @(posedge clk);
        slot_valid <= 1'b1;
        slot_index <= 5'd0;
        slot_data <= d0;
        @(posedge clk);
        slot_index <= 5'd31;
        slot_data <= d31;
        @(posedge clk);
        slot_valid <= 1'b0;
        frame_end <= 1'b1;
        @(posedge clk);
        frame_end <= 1'b0;
        do @(posedge clk); while (dac5_valid !== 1'b1);
        @(posedge clk);
        got = rail_code;
    endtask
    // one audio word on either path; answer due one cycle after it is taken
    task automatic pulse(input logic five, input logic [23:0] d);
        @(posedge clk);
        if (five) aud5_valid <= 1'b1;
        else aud_valid <= 1'b1;
        if (five) aud5_data <= d;
        else aud_data <= d;
        @(posedge clk);
        aud_valid <= 1'b0;
        aud5_valid <= 1'b0;
        @(posedge clk);
        vld = five ? dac5_valid : dly_valid;
        dat = five ? dac5_data : dly_data;
    endtask
    // ****
    // tests
    // ****
    initial begin
        {resetn, avs_read, avs_write, slot_valid, frame_end, aud_valid, aud5_valid} = '0;
        {avs_address, avs_writedata, avs_byteenable, slot_index, slot_data, aud_data, aud5_data} = '0;
        do_reset();
        chkrd("ctrl", REG_CTRL, 32'h040);
        chkrd("vol", REG_VOL, 32'h10);
        chkrd("slot_en", REG_SLOT_EN, 32'hffffffff);
        chkrd("env", REG_ENV, 32'h0);
        chkrd("peak", REG_PEAK, 32'h0);
        chkrd("unmapped", 8'h14, 32'h0);
        av(1'b1, REG_CTRL, 32'h00000f00, 4'b0010); // upper lane only
        chkrd("ctrl_lane", REG_CTRL, 32'hf40);
        wr(REG_ENV, 32'h123); // read-only, must not stick
        chkrd("env_ro", REG_ENV, 32'h0);
        wr(REG_CTRL, 32'h040);
        $display("test registers done");
        // negative sample on the last slot sets the frame peak
        frame(24'h001000, 24'he00000);
        `CHK("dac5", 24'h200000, got)
        chkrd("peak", REG_PEAK, 32'h200000);
        // slot 31 disabled: its full-scale sample must not count, envelope releases
        wr(REG_SLOT_EN, 32'h1);
        frame(24'h001000, 24'h7fffff);
        `CHK("dac5_decay", 24'h1f7fff, got)
        chkrd("peak_en", REG_PEAK, 32'h001000);
        chkrd("env_decay", REG_ENV, 32'h1f7fff);
        $display("test envelope done");
        do_reset();
        for (int s = 0; s < 8; s++) begin
            wr(REG_CTRL, 32'h040 | s);
            frame(24'h100000, 24'h0);
            `CHK("headroom", 24'h100000 + 24'((32'h7fffff * pct[s]) / 100), got)
        end
        for (int i = 0; i < 10; i++) begin
            wr(REG_CTRL, {20'h0, tc[i]});
            wr(REG_VOL, {24'h0, tv[i]});
            frame(24'h100000, 24'h0);
            `CHK("gain_mode", te[i], got)
        end
        $display("test tracking done");
        // plain audio must not reach the fifth dac while tracking
        wr(REG_VOL, 32'h10);
        wr(REG_CTRL, 32'h040);
        pulse(1'b1, 24'h123456);
        `CHK("aud5_blocked", 1'b0, vld)
        for (int f = 0; f < 6; f++) begin
            if (f % 3 == 2) continue;
            wr(REG_CTRL, ((f / 3) << 7) | (f << 5)); // filter 00, 01 plain, then 11 and 00 with invert
            pulse(1'b1, 24'h123456);
            `CHK("aud5_valid", 1'b1, vld)
            `CHK("aud5_data", (f >= 3) ? 24'hedcbaa : 24'h123456, dat)
        end
        $display("test plain path done");
        for (int g = 0; g < 16; g += 15) begin
            wr(REG_CTRL, 32'h040 | (g << 8));
            nd = ((100 + (g * 400) / 15) * 48000) / 1000000;
            for (int k = 1; k <= 30; k++) begin
                pulse(1'b0, 24'(k));
                `CHK("dly_valid", 1'b1, vld)
                if (k > nd) `CHK("dly_data", 24'(k - nd), dat)
            end
        end
        $display("test group delay done");
        end_of_test();
    end
endmodule
